// file: design/snfe_front_end.sv
// Serial command front end: framing, opcode decode, status registers and array command issue
`include "snfe_params.svh"
`timescale 1ns/10ps
`default_nettype none

module snfe_front_end #(
	parameter logic [7:0]  MAKER_CODE  = 8'h5a,   // Arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h1234 // Arbitrary value
) (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          sclk_pin,
	input  wire logic          cs_b_pin,
	input  wire logic          serial_input,
	input  wire logic          busy,
	input  wire logic [15:0]   ecc_fail_page,
	input  wire logic [31:0]   lut_entry,
	output logic               so_out,
	output logic               so_oe_b,
	output logic [7:0]         lut_index,
	output snfe_pkg::snfe_cmd_t  cmd,
	output logic               cmd_valid,
	output snfe_pkg::snfe_load_t load,
	output logic               load_valid,
	output logic               load_start,
	output logic               load_done,
	output logic               deep_power_down,
	output logic               write_enable,
	output logic [7:0]         learning_pattern_value
);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  cs_b;
	logic                  cs_rise;
	logic                  cs_fall;
	logic                  si;
	snfe_pkg::snfe_state_t state;
	snfe_pkg::snfe_state_t next_state;
	logic [2:0]            bit_cnt;
	logic [7:0]            byte_cnt;
	logic [7:0]            next_byte_cnt;
	logic [6:0]            shreg;
	logic [7:0]            rx_byte;
	logic                  byte_done;
	logic [7:0]            opcode;
	logic [3:0]            sel;
	logic [31:0]           arg;
	logic [15:0]           column;
	logic [7:0]            tx;
	logic [7:0]            next_tx;
	logic [1:0]            lut_k;
	logic [7:0]            sr1;
	logic [7:0]            sr2;
	logic [7:0]            sr4;
	logic                  reset_armed;
	logic                  end_ok;
	logic                  in_body;
	logic                  accept;

	snfe_sync #(.RESET_VALUE(1'b0)) u_sclk (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (sclk_pin),
		.level    (),
		.rise     (sclk_rise),
		.fall     (sclk_fall)
	);

	snfe_sync #(.RESET_VALUE(1'b1)) u_cs (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (cs_b_pin),
		.level    (cs_b),
		.rise     (cs_rise),
		.fall     (cs_fall)
	);

	snfe_sync #(.RESET_VALUE(1'b0)) u_si (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (serial_input),
		.level    (si),
		.rise     (),
		.fall     ()
	);

	function automatic logic is_read(input logic [7:0] op);
		return op == `SNFE_OP_ID || op == `SNFE_OP_RDSR_A || op == `SNFE_OP_RDSR_B ||
			op == `SNFE_OP_LUT || op == `SNFE_OP_ECCF;
	endfunction

	function automatic logic is_load(input logic [7:0] op);
		return op == `SNFE_OP_LOAD || op == `SNFE_OP_RLOAD || op == `SNFE_OP_QLOAD || op == `SNFE_OP_RQLOAD;
	endfunction

	function automatic logic is_known(input logic [7:0] op);
		return is_read(op) || is_load(op) || op == `SNFE_OP_RESET || op == `SNFE_OP_RST_ARM ||
			op == `SNFE_OP_RST_GO || op == `SNFE_OP_WRSR_A || op == `SNFE_OP_WRSR_B ||
			op == `SNFE_OP_DLP || op == `SNFE_OP_WREN || op == `SNFE_OP_WRDI ||
			op == `SNFE_OP_DPD || op == `SNFE_OP_DPD_EXIT || op == `SNFE_OP_SWAP ||
			op == `SNFE_OP_ERASE || op == `SNFE_OP_EXEC;
	endfunction

	// Protected ranges are whole multiples of two blocks, so a page hit equals a block hit
	function automatic logic prot_hit(input logic [7:0] s1, input logic [15:0] page);
		logic [3:0]  bp;
		logic [16:0] size;
		bp   = s1[`SNFE_SR1_BP_MSB:`SNFE_SR1_BP_LSB];
		size = `SNFE_PROT_UNIT << (bp - 4'h1);
		if (bp == 4'h0)
			return 1'b0;
		else if (bp >= `SNFE_BP_ALL)
			return 1'b1;
		else if (s1[`SNFE_SR1_TB])
			return {1'b0, page} < size;
		else
			return {1'b0, page} >= (`SNFE_PAGE_SPAN - size);
	endfunction

	function automatic logic [7:0] sr_pick(input logic [3:0] s, input logic [7:0] r1, input logic [7:0] r2,
		input logic [7:0] r3, input logic [7:0] r4);
		case (s)
			`SNFE_SEL_SR1: return r1;
			`SNFE_SEL_SR2: return r2;
			`SNFE_SEL_SR3: return r3;
			`SNFE_SEL_SR4: return r4;
			default:       return 8'h00;
		endcase
	endfunction

	logic [7:0] sr3;
	always_comb begin
		sr3 = 8'h00;
		sr3[`SNFE_SR3_BUSY] = busy;
		sr3[`SNFE_SR3_WEL]  = write_enable;
	end

	assign rx_byte       = {shreg, si};
	assign byte_done     = sclk_rise && state != snfe_pkg::SNFE_IDLE && bit_cnt == 3'h7;
	assign next_byte_cnt = (byte_cnt == 8'hff) ? byte_cnt : byte_cnt + 8'h01;
	assign in_body       = state == snfe_pkg::SNFE_BODY;
	assign end_ok        = cs_rise && in_body && bit_cnt == 3'h0;

	// Busy and power-down gate the opcode; unknown opcodes drop the frame
	always_comb begin
		accept = is_known(rx_byte);
		if (busy && !(rx_byte == `SNFE_OP_ID || rx_byte == `SNFE_OP_RDSR_A || rx_byte == `SNFE_OP_RDSR_B))
			accept = 1'b0;
		if (deep_power_down && rx_byte != `SNFE_OP_DPD_EXIT)
			accept = 1'b0;
	end

	always_comb begin
		next_state = state;
		if (cs_fall)
			next_state = snfe_pkg::SNFE_OPCODE;
		else if (cs_rise || cs_b)
			next_state = snfe_pkg::SNFE_IDLE;
		else if (byte_done && state == snfe_pkg::SNFE_OPCODE)
			next_state = accept ? snfe_pkg::SNFE_BODY : snfe_pkg::SNFE_DISCARD;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			state <= snfe_pkg::SNFE_IDLE;
		else
			state <= next_state;
	end

	// Bit and byte counting
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 8'h00;
			shreg    <= 7'h00;
		end else if (cs_fall) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 8'h00;
		end else if (sclk_rise && state != snfe_pkg::SNFE_IDLE) begin
			shreg   <= rx_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7)
				byte_cnt <= next_byte_cnt;
		end
	end

	// Opcode, select and argument capture
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			opcode <= 8'h00;
			sel    <= 4'h0;
			arg    <= 32'h0;
		end else if (byte_done) begin
			if (state == snfe_pkg::SNFE_OPCODE)
				opcode <= rx_byte;
			if (in_body && byte_cnt == 8'h01)
				sel <= rx_byte[7:4];
			if (in_body && byte_cnt >= 8'h01 && byte_cnt <= 8'h04)
				arg <= {arg[23:0], rx_byte};
		end
	end

	// Buffer load streaming; the backend keeps the buffer only on load_done
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			column     <= 16'h0000;
			load       <= '0;
			load_valid <= 1'b0;
			load_start <= 1'b0;
			load_done  <= 1'b0;
		end else begin
			load_valid <= 1'b0;
			load_start <= 1'b0;
			load_done  <= 1'b0;
			if (byte_done && in_body && is_load(opcode)) begin
				if (byte_cnt == 8'h02) begin
					column            <= {arg[7:0], rx_byte};
					load_start        <= 1'b1;
					load.random       <= opcode == `SNFE_OP_RLOAD || opcode == `SNFE_OP_RQLOAD;
					load.column       <= {arg[7:0], rx_byte};
				end else if (byte_cnt >= 8'h03) begin
					load.column <= column;
					load.data   <= rx_byte;
					load_valid  <= 1'b1;
					column      <= column + 16'h0001;
				end
			end
			if (end_ok && is_load(opcode) && byte_cnt >= `SNFE_LEN_LOAD_MIN)
				load_done <= 1'b1;
		end
	end

	// Next output byte for read commands
	always_comb begin
		next_tx = 8'h00;
		case (opcode)
			`SNFE_OP_ID: begin
				if (next_byte_cnt == `SNFE_OUT_FIRST)
					next_tx = MAKER_CODE;
				else if (next_byte_cnt == `SNFE_OUT_FIRST + 8'h01)
					next_tx = DEVICE_CODE[15:8];
				else if (next_byte_cnt == `SNFE_OUT_FIRST + 8'h02)
					next_tx = DEVICE_CODE[7:0];
			end
			`SNFE_OP_RDSR_A, `SNFE_OP_RDSR_B: begin
				next_tx = sr_pick((byte_cnt == 8'h01) ? rx_byte[7:4] : sel, sr1, sr2, sr3, sr4);
			end
			`SNFE_OP_LUT: begin
				next_tx = lut_entry[8'd31 - {lut_k, 3'b000} -: 8];
			end
			`SNFE_OP_ECCF: begin
				if (next_byte_cnt == `SNFE_OUT_FIRST)
					next_tx = ecc_fail_page[15:8];
				else if (next_byte_cnt == `SNFE_OUT_FIRST + 8'h01)
					next_tx = ecc_fail_page[7:0];
			end
			default: next_tx = 8'h00;
		endcase
	end

	// Output shifter: loaded at the byte edge, shifted on each falling clock
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx        <= 8'h00;
			so_out    <= 1'b0;
			so_oe_b   <= 1'b1;
			lut_k     <= 2'h0;
			lut_index <= 8'h00;
		end else begin
			so_oe_b <= !(in_body && !cs_b && is_read(opcode) && byte_cnt >= `SNFE_OUT_FIRST);
			if (cs_fall) begin
				lut_k     <= 2'h0;
				lut_index <= 8'h00;
			end else if (byte_done && in_body && is_read(opcode)) begin
				tx <= next_tx;
				if (opcode == `SNFE_OP_LUT && next_byte_cnt >= `SNFE_OUT_FIRST) begin
					lut_k <= lut_k + 2'h1;
					if (lut_k == 2'h3)
						lut_index <= lut_index + 8'h01;
				end
			end else if (sclk_fall && in_body) begin
				so_out <= tx[7];
				tx     <= {tx[6:0], 1'b0};
			end
		end
	end

	// Frame-end commit of register writes and mode changes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sr1                    <= `SNFE_SR1_RST;
			sr2                    <= `SNFE_SR2_RST;
			sr4                    <= `SNFE_SR4_RST;
			write_enable           <= 1'b0;
			deep_power_down        <= 1'b0;
			reset_armed            <= 1'b0;
			learning_pattern_value <= `SNFE_DLP_RST;
		end else if (cs_rise && state != snfe_pkg::SNFE_IDLE) begin
			reset_armed <= end_ok && opcode == `SNFE_OP_RST_ARM && byte_cnt == `SNFE_LEN_SINGLE;
			if (end_ok) begin
				case (opcode)
					`SNFE_OP_WREN:
						if (byte_cnt == `SNFE_LEN_SINGLE)
							write_enable <= 1'b1;
					`SNFE_OP_WRDI:
						if (byte_cnt == `SNFE_LEN_SINGLE)
							write_enable <= 1'b0;
					`SNFE_OP_DPD:
						if (byte_cnt == `SNFE_LEN_SINGLE)
							deep_power_down <= 1'b1;
					`SNFE_OP_DPD_EXIT:
						if (byte_cnt == `SNFE_LEN_SINGLE)
							deep_power_down <= 1'b0;
					`SNFE_OP_RESET, `SNFE_OP_RST_GO:
						if (byte_cnt == `SNFE_LEN_SINGLE && (opcode == `SNFE_OP_RESET || reset_armed))
							write_enable <= 1'b0;
					`SNFE_OP_DLP:
						if (byte_cnt == `SNFE_LEN_DLP)
							learning_pattern_value <= arg[7:0];
					`SNFE_OP_WRSR_A, `SNFE_OP_WRSR_B:
						if (byte_cnt == `SNFE_LEN_WRSR) begin
							case (sel)
								`SNFE_SEL_SR1: sr1 <= arg[7:0];
								`SNFE_SEL_SR2: sr2 <= arg[7:0];
								`SNFE_SEL_SR4: sr4 <= arg[7:0];
								default:       sr1 <= sr1;
							endcase
						end
					default: write_enable <= write_enable;
				endcase
			end
		end
	end

	// Array commands issued at a clean frame end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cmd       <= '0;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (end_ok) begin
				cmd.page                  <= arg[15:0];
				cmd.logical_block_number  <= arg[31:16];
				cmd.physical_block_number <= arg[15:0];
				if ((opcode == `SNFE_OP_RESET || (opcode == `SNFE_OP_RST_GO && reset_armed))
					&& byte_cnt == `SNFE_LEN_SINGLE) begin
					cmd.kind  <= snfe_pkg::SNFE_K_RESET;
					cmd_valid <= 1'b1;
				end else if (opcode == `SNFE_OP_SWAP && byte_cnt == `SNFE_LEN_SWAP) begin
					cmd.kind  <= snfe_pkg::SNFE_K_SWAP;
					cmd_valid <= 1'b1;
				end else if (opcode == `SNFE_OP_ERASE && byte_cnt == `SNFE_LEN_PAGE) begin
					cmd.kind  <= snfe_pkg::SNFE_K_ERASE;
					cmd_valid <= !prot_hit(sr1, arg[15:0]);
				end else if (opcode == `SNFE_OP_EXEC && byte_cnt == `SNFE_LEN_PAGE) begin
					cmd.kind  <= snfe_pkg::SNFE_K_EXEC;
					cmd_valid <= !prot_hit(sr1, arg[15:0]);
				end
			end
		end
	end

	a_frame_start: assert property (cs_fall |=> bit_cnt == 3'h0 && byte_cnt == 8'h00 && state == snfe_pkg::SNFE_OPCODE)
		else $error("frame did not restart on select fall");
	a_opcode_capture: assert property (byte_done && state == snfe_pkg::SNFE_OPCODE && !cs_rise |=> opcode == $past(rx_byte))
		else $error("opcode not taken from first byte");
	a_msb_first: assert property (sclk_rise && state != snfe_pkg::SNFE_IDLE && !cs_fall |=> shreg[0] == $past(si))
		else $error("input bit not shifted in at low end");
	a_frame_close: assert property (cs_rise |=> state == snfe_pkg::SNFE_IDLE)
		else $error("frame not closed on select rise");
	a_partial_ignored: assert property (cs_rise && bit_cnt != 3'h0 |=> !cmd_valid && !load_done)
		else $error("partial byte frame took effect");
	a_busy_gate: assert property (byte_done && state == snfe_pkg::SNFE_OPCODE && busy && !cs_rise
		&& rx_byte != `SNFE_OP_ID && rx_byte != `SNFE_OP_RDSR_A && rx_byte != `SNFE_OP_RDSR_B
		|=> state == snfe_pkg::SNFE_DISCARD)
		else $error("command accepted while busy");
	a_protect_gate: assert property (cmd_valid && (cmd.kind == snfe_pkg::SNFE_K_ERASE
		|| cmd.kind == snfe_pkg::SNFE_K_EXEC) |-> !prot_hit(sr1, cmd.page))
		else $error("protected page was targeted");
	a_wel_set: assert property (end_ok && opcode == `SNFE_OP_WREN && byte_cnt == 8'h01 |=> write_enable ##1 write_enable)
		else $error("write enable not set");
	a_dpd_enter: assert property (end_ok && opcode == `SNFE_OP_DPD && byte_cnt == 8'h01 |=> deep_power_down)
		else $error("power-down not entered");
	a_unknown_drop: assert property (state == snfe_pkg::SNFE_DISCARD && !cs_rise |=> !cmd_valid && $stable(sr1))
		else $error("discarded frame changed state");

	c_status_read: cover property (in_body && opcode == `SNFE_OP_RDSR_A && !so_oe_b);
	c_erase: cover property (cmd_valid && cmd.kind == snfe_pkg::SNFE_K_ERASE);
	c_load: cover property (load_done);
	c_reset_pair: cover property (cmd_valid && cmd.kind == snfe_pkg::SNFE_K_RESET && $past(reset_armed));

endmodule

`default_nettype wire

// file: design/snfe_params.svh
// Opcodes, field positions, reset values and frame lengths of the serial command front end
`ifndef SNFE_PARAMS_SVH
`define SNFE_PARAMS_SVH

`define SNFE_OP_RESET      8'hff
`define SNFE_OP_RST_ARM    8'h66
`define SNFE_OP_RST_GO     8'h99
`define SNFE_OP_ID         8'h9f
`define SNFE_OP_RDSR_A     8'h0f
`define SNFE_OP_RDSR_B     8'h05
`define SNFE_OP_WRSR_A     8'h1f
`define SNFE_OP_WRSR_B     8'h01
`define SNFE_OP_DLP        8'h4a
`define SNFE_OP_WREN       8'h06
`define SNFE_OP_WRDI       8'h04
`define SNFE_OP_DPD        8'hb9
`define SNFE_OP_DPD_EXIT   8'hab
`define SNFE_OP_SWAP       8'ha1
`define SNFE_OP_LUT        8'ha5
`define SNFE_OP_ECCF       8'ha9
`define SNFE_OP_ERASE      8'hd8
`define SNFE_OP_LOAD       8'h02
`define SNFE_OP_RLOAD      8'h84
`define SNFE_OP_QLOAD      8'h32
`define SNFE_OP_RQLOAD     8'h34
`define SNFE_OP_EXEC       8'h10

`define SNFE_SEL_SR1       4'ha
`define SNFE_SEL_SR2       4'hb
`define SNFE_SEL_SR3       4'hc
`define SNFE_SEL_SR4       4'hd

`define SNFE_SR1_TB        2
`define SNFE_SR1_BP_LSB    3
`define SNFE_SR1_BP_MSB    6
`define SNFE_SR3_BUSY      0
`define SNFE_SR3_WEL       1

`define SNFE_SR1_RST       8'h00
`define SNFE_SR2_RST       8'h00
`define SNFE_SR4_RST       8'h00
`define SNFE_DLP_RST       8'h34

`define SNFE_PROT_UNIT     17'h00080
`define SNFE_PAGE_SPAN     17'h10000
`define SNFE_BP_ALL        4'ha

`define SNFE_LEN_SINGLE    8'h01
`define SNFE_LEN_DLP       8'h02
`define SNFE_LEN_WRSR      8'h03
`define SNFE_LEN_PAGE      8'h04
`define SNFE_LEN_SWAP      8'h05
`define SNFE_LEN_LOAD_MIN  8'h03
`define SNFE_OUT_FIRST     8'h02

`endif

// file: design/snfe_pkg.sv
// Types shared by the serial command front end
package snfe_pkg;

	typedef enum logic [1:0] {
		SNFE_IDLE,
		SNFE_OPCODE,
		SNFE_BODY,
		SNFE_DISCARD
	} snfe_state_t;

	typedef enum logic [1:0] {
		SNFE_K_RESET,
		SNFE_K_SWAP,
		SNFE_K_ERASE,
		SNFE_K_EXEC
	} snfe_kind_t;

	typedef struct packed {
		snfe_kind_t  kind;
		logic [15:0] page;
		logic [15:0] logical_block_number;
		logic [15:0] physical_block_number;
	} snfe_cmd_t;

	typedef struct packed {
		logic        random;
		logic [15:0] column;
		logic [7:0]  data;
	} snfe_load_t;

endpackage

// file: design/snfe_sync.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/10ps
`default_nettype none

module snfe_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic meta;
	logic stage;
	logic prev;

	// Only stage reads meta; edges come from stage and prev
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta  <= RESET_VALUE;
			stage <= RESET_VALUE;
			prev  <= RESET_VALUE;
		end else begin
			meta  <= async_in;
			stage <= meta;
			prev  <= stage;
		end
	end

	assign level = stage;
	assign rise  = stage & ~prev;
	assign fall  = ~stage & prev;

endmodule

`default_nettype wire

// file: testbench/snfe_front_end_tb.sv
// Self-checking bench for the serial command front end
`timescale 1ns/10ps
`default_nettype none

module snfe_front_end_tb;
	localparam logic [7:0]  MAKER = 8'hc3;    // Arbitrary value
	localparam logic [15:0] DEV   = 16'h6a29; // Arbitrary value
	logic                 clock = 1'b0;
	logic                 rst_b;
	logic                 busy;
	logic [15:0]          ecc_fail_page;
	logic [31:0]          lut_entry;
	logic                 sclk_pin;
	logic                 cs_b_pin;
	logic                 serial_input;
	logic                 so_out;
	logic                 so_oe_b;
	logic [7:0]           lut_index;
	snfe_pkg::snfe_cmd_t  cmd;
	snfe_pkg::snfe_cmd_t  last_cmd;
	logic                 cmd_valid;
	snfe_pkg::snfe_load_t load;
	snfe_pkg::snfe_load_t last_st;
	snfe_pkg::snfe_load_t last_ld;
	logic                 load_valid;
	logic                 load_start;
	logic                 load_done;
	logic                 deep_power_down;
	logic                 write_enable;
	logic [7:0]           learning_pattern_value;
	logic [31:0]          seed = 32'h00014101;
	logic [31:0]          salt;
	logic [63:0]          rxv;
	logic [7:0]           d;
	logic [15:0]          p;
	logic [15:0]          q;
	logic [7:0]           ops [4] = '{8'h02, 8'h84, 8'h32, 8'h34};
	logic [7:0]           sels [3] = '{8'ha0, 8'hb0, 8'hd0};
	int                   n_fail = 0;
	int                   comparisons = 0;
	int                   n_cmd = 0;
	int                   n_ld = 0;
	int                   n_done = 0;
	int                   n0;
	int                   dn0;

	always #2 clock = ~clock;

	snfe_host_model u_host (
		.clock        (clock),
		.sclk_pin     (sclk_pin),
		.cs_b_pin     (cs_b_pin),
		.serial_input (serial_input),
		.so_out       (so_out),
		.so_oe_b      (so_oe_b)
	);

	snfe_front_end #(
		.MAKER_CODE  (MAKER),
		.DEVICE_CODE (DEV)
	) u_dut (
		.clock                  (clock),
		.rst_b                  (rst_b),
		.sclk_pin               (sclk_pin),
		.cs_b_pin               (cs_b_pin),
		.serial_input           (serial_input),
		.busy                   (busy),
		.ecc_fail_page          (ecc_fail_page),
		.lut_entry              (lut_entry),
		.so_out                 (so_out),
		.so_oe_b                (so_oe_b),
		.lut_index              (lut_index),
		.cmd                    (cmd),
		.cmd_valid              (cmd_valid),
		.load                   (load),
		.load_valid             (load_valid),
		.load_start             (load_start),
		.load_done              (load_done),
		.deep_power_down        (deep_power_down),
		.write_enable           (write_enable),
		.learning_pattern_value (learning_pattern_value)
	);

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] lut_val(input logic [7:0] i);
		return salt ^ {4{i}};
	endfunction

	function automatic logic is_random(input logic [7:0] op);
		return (op == 8'h84) || (op == 8'h34);
	endfunction

	// Pulses are sampled mid-cycle, away from the launching edge
	always @(negedge clock) begin
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			last_cmd = cmd;
		end
		if (load_start === 1'b1)
			last_st = load;
		if (load_valid === 1'b1) begin
			n_ld++;
			last_ld = load;
		end
		if (load_done === 1'b1)
			n_done++;
	end

	always @(posedge clock)
		lut_entry <= lut_val(lut_index);

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Whole bytes from the top of tx, then extra stray bits
	task automatic frame(input logic [79:0] tx, input int nb, input int extra);
		logic [7:0] r;
		rxv = 64'h0;
		u_host.open_frame();
		for (int k = nb - 1; k >= 0; k--) begin
			u_host.shift(tx[k*8 +: 8], 8, r);
			rxv = {rxv[55:0], r};
		end
		if (extra > 0)
			u_host.shift(8'ha5, extra, r);
		u_host.close_frame();
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#300000;
		n_fail++;
		$display("Error watchdog expected finish seen hang");
		close_out();
	end

	initial begin
		rst_b = 1'b0;
		busy = 1'b0;
		ecc_fail_page = 16'h0000;
		salt = rnd();
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		check("write_enable", 1'b0, write_enable);
		check("pattern", 8'h34, learning_pattern_value);
		check("power down", 1'b0, deep_power_down);
		frame({8'h9f, rnd()}, 5, 0);
		check("id", {MAKER, DEV}, rxv[23:0]);
		check("released", 1'b1, so_oe_b);
		done("reset and id");
		frame(8'h06, 1, 3);
		check("partial enable", 1'b0, write_enable);
		frame(8'h06, 1, 0);
		check("enable", 1'b1, write_enable);
		frame(24'h0fc000, 3, 0);
		check("status3 wel", 2'b10, rxv[1:0]);
		frame(8'h04, 1, 0);
		check("disable", 1'b0, write_enable);
		done("write enable");
		for (int i = 0; i < 3; i++) begin
			d = 8'(rnd());
			frame({(i[0] ? 8'h01 : 8'h1f), sels[i], d}, 3, 0);
			frame({(i[0] ? 8'h05 : 8'h0f), sels[i], 16'h0}, 4, 3);
			check("status", {d, d}, rxv[15:0]);
		end
		frame(24'h1fc0ff, 3, 0);
		frame(24'h0fc000, 3, 0);
		check("status3 write", 2'b00, rxv[1:0]);
		frame(24'h1fa000, 3, 0);
		d = 8'(rnd());
		frame({8'h4a, d}, 2, 0);
		check("pattern", d, learning_pattern_value);
		frame({8'h4a, ~d}, 2, 5);
		check("partial pattern", d, learning_pattern_value);
		done("status");
		for (int i = 0; i < 4; i++) begin
			if (i == 2)
				frame({16'h1fa0, 1'b0, 4'ha, 3'b000}, 3, 0);
			p = 16'(rnd());
			n0 = n_cmd;
			frame({(i[0] ? 8'h10 : 8'hd8), 8'(rnd()), p}, 4, 0);
			check("command count", 64'(n0 + (i < 2)), 64'(n_cmd));
			if (i < 2)
				check("command", {(i[0] ? snfe_pkg::SNFE_K_EXEC : snfe_pkg::SNFE_K_ERASE), p},
					{last_cmd.kind, last_cmd.page});
		end
		frame(24'h1fa00c, 3, 0);
		n0 = n_cmd;
		frame({8'hd8, 8'h00, 16'h007f}, 4, 0);
		frame({8'hd8, 8'h00, 16'h0080}, 4, 0);
		check("lower guard", 64'(n0 + 1), 64'(n_cmd));
		check("lower page", 16'h0080, last_cmd.page);
		frame(24'h1fa048, 3, 0);
		frame({8'h10, 8'h00, 16'h8000}, 4, 0);
		frame({8'h10, 8'h00, 16'h7fff}, 4, 0);
		check("upper guard", 64'(n0 + 2), 64'(n_cmd));
		check("upper page", 16'h7fff, last_cmd.page);
		frame(24'h1fa000, 3, 0);
		p = 16'(rnd());
		q = 16'(rnd());
		frame({8'ha1, p, q}, 5, 0);
		check("swap", {snfe_pkg::SNFE_K_SWAP, p, q}, {last_cmd.kind, last_cmd[31:0]});
		n0 = n_cmd;
		frame({8'hd8, 8'h00, p}, 4, 4);
		check("partial erase", 64'(n0), 64'(n_cmd));
		done("array commands");
		frame(8'h06, 1, 0);
		busy <= 1'b1;
		frame(8'h04, 1, 0);
		check("busy disable", 1'b1, write_enable);
		frame(24'h05c000, 3, 0);
		check("status3 busy", 2'b11, rxv[1:0]);
		frame({8'h9f, 32'h0}, 5, 0);
		check("busy id", {MAKER, DEV}, rxv[23:0]);
		busy <= 1'b0;
		done("busy");
		frame(8'h06, 1, 0);
		frame(8'hff, 1, 0);
		check("reset kind", snfe_pkg::SNFE_K_RESET, last_cmd.kind);
		check("reset wel", 1'b0, write_enable);
		frame(8'h06, 1, 0);
		n0 = n_cmd;
		frame(8'h66, 1, 0);
		frame({8'h77, 8'(rnd())}, 2, 0);
		frame(8'h99, 1, 0);
		check("disarmed", 64'(n0), 64'(n_cmd));
		check("unknown op", 1'b1, write_enable);
		frame(8'h66, 1, 0);
		frame(8'h99, 1, 0);
		check("reset pair", 64'(n0 + 1), 64'(n_cmd));
		check("reset pair wel", 1'b0, write_enable);
		frame(8'h06, 1, 0);
		frame(8'hb9, 1, 0);
		check("power down", 1'b1, deep_power_down);
		frame(8'h04, 1, 0);
		check("asleep disable", 1'b1, write_enable);
		frame(8'hab, 1, 0);
		check("wake", 1'b0, deep_power_down);
		done("reset and power");
		ecc_fail_page <= 16'(rnd());
		frame({8'ha9, 24'h0}, 4, 0);
		check("ecc page", ecc_fail_page, rxv[15:0]);
		frame({8'ha5, 72'h0}, 10, 0);
		check("remap", {lut_val(8'h00), lut_val(8'h01)}, rxv);
		done("read outs");
		dn0 = n_done;
		for (int i = 0; i < 4; i++) begin
			p = 16'(rnd());
			d = 8'(rnd());
			n0 = n_ld;
			frame({ops[i], p, ~d, d}, 5, 0);
			check("load start", {is_random(ops[i]), p}, {last_st.random, last_st.column});
			check("load bytes", 64'(n0 + 2), 64'(n_ld));
			check("load data", d, last_ld.data);
			check("load column", p + 16'h0001, last_ld.column);
			check("load done", 64'(dn0 + i + 1), 64'(n_done));
		end
		frame({8'h02, p, d}, 4, 3);
		check("partial load", 64'(dn0 + 4), 64'(n_done));
		done("loads");
		close_out();
	end
endmodule

`default_nettype wire

// file: testbench/snfe_host_model.sv
// Host serial controller model that drives command frames
`timescale 1ns/10ps
`default_nettype none

module snfe_host_model (
	input  wire logic clock,
	output logic      sclk_pin,
	output logic      cs_b_pin,
	output logic      serial_input,
	input  wire logic so_out,
	input  wire logic so_oe_b
);
	initial begin
		sclk_pin = 1'b0;
		cs_b_pin = 1'b1;
		serial_input = 1'b0;
	end

	// Clock stands low outside frames
	task automatic open_frame();
		@(posedge clock);
		cs_b_pin <= 1'b0;
		repeat (16) @(posedge clock);
	endtask

	// Roughly 125 ns per bit; output sampled as the clock rises
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			serial_input <= tx[i];
			repeat (15) @(posedge clock);
			sclk_pin <= 1'b1;
			// Undriven output reads inverted so a stale bit cannot pass
			rx[i] = so_oe_b ? ~so_out : so_out;
			repeat (16) @(posedge clock);
			sclk_pin <= 1'b0;
		end
	endtask

	// Released data line shows the inverse so a stale bit cannot pass
	task automatic close_frame();
		repeat (8) @(posedge clock);
		cs_b_pin <= 1'b1;
		serial_input <= ~serial_input;
		repeat (24) @(posedge clock);
	endtask
endmodule

`default_nettype wire
